// ---- hdl/pacd_pkg.sv ----
`default_nettype none
package pacd_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NCH        = 4;
    localparam int CH_W       = 2;
    localparam int SMP_W      = 17;
    localparam int OUT_W      = 16;
    localparam int BUS_MSB_W  = 14;
    localparam int PWR_W      = 31;
    localparam int ACC_W      = 48;
    localparam int CNT_W      = 24;
    localparam int MEAN_DEPTH = 8;
    localparam int MEAN_SHIFT = 3;
    localparam int MEAN_SUM_W = 20;
    localparam int PERM_W     = 2;
    localparam int SETTLE_W   = 4;

    // ----------------------------------------
    // limits and reset values
    // ----------------------------------------
    localparam logic [ACC_W-1:0]    ACC_MAX       = 48'h7fff_ffff_ffff;
    localparam logic [ACC_W-1:0]    ACC_MIN       = 48'h8000_0000_0000;
    localparam logic [ACC_W-1:0]    ACC_RST       = 48'h0;
    localparam logic [CNT_W-1:0]    CNT_MAX       = 24'hff_ffff;
    localparam logic [CNT_W-1:0]    CNT_RST       = 24'h0;
    localparam logic [SETTLE_W-1:0] SETTLE_CYCLES = 4'h8;
    localparam logic [PERM_W-1:0]   PERM_RST      = 2'h0;
    localparam logic [OUT_W-1:0]    OUT_RST       = 16'h0;

    typedef logic signed [SMP_W-1:0] pacd_smp_t;
    typedef logic [CH_W-1:0]         pacd_ch_t;

    // ----------------------------------------
    // readable format
    // ----------------------------------------
    // bipolar drops the extra lsb; unipolar clamps negatives to zero
    function automatic logic [OUT_W-1:0] fmt_result(
        input pacd_smp_t v,
        input logic      bipolar
    );
        if (bipolar) begin
            return v[SMP_W-1:1];
        end else if (v[SMP_W-1]) begin
            return OUT_RST;
        end else begin
            return v[OUT_W-1:0];
        end
    endfunction

endpackage
`default_nettype wire

// ---- hdl/pacd_conv_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface pacd_conv_if;
    logic               valid;
    pacd_pkg::pacd_ch_t ch;
    pacd_pkg::pacd_smp_t bus;
    pacd_pkg::pacd_smp_t sense;
    logic               cycle_done;

    modport src  (output valid, ch, bus, sense, cycle_done);
    modport sink (input  valid, ch, bus, sense, cycle_done);
endinterface // pacd_conv_if
`default_nettype wire

// ---- hdl/pacd_mean.sv ----
`timescale 1ns/1ns
`default_nettype none
module pacd_mean (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                push,
    input  wire pacd_pkg::pacd_smp_t sample,
    output var  pacd_pkg::pacd_smp_t mean
);
    pacd_pkg::pacd_smp_t hist [pacd_pkg::MEAN_DEPTH-1];
    logic signed [pacd_pkg::MEAN_SUM_W-1:0] next_sum;
    pacd_pkg::pacd_smp_t next_mean;

    always_comb begin
        next_sum = pacd_pkg::MEAN_SUM_W'(sample);
        for (int i = 0; i < pacd_pkg::MEAN_DEPTH - 1; i++) begin
            next_sum = next_sum + pacd_pkg::MEAN_SUM_W'(hist[i]);
        end
    end
    assign next_mean = pacd_pkg::SMP_W'(next_sum >>> pacd_pkg::MEAN_SHIFT);

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < pacd_pkg::MEAN_DEPTH - 1; i++) begin
                hist[i] <= '0;
            end
            mean <= '0;
        end else if (push) begin
            hist[0] <= sample;
            for (int i = 1; i < pacd_pkg::MEAN_DEPTH - 1; i++) begin
                hist[i] <= hist[i-1];
            end
            mean <= next_mean;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    mean_held_a: assert property (!push |=> $stable(mean))
        else $error("mean changed without cycle end");
    mean_calc_a: assert property (push |=> mean == $past(next_mean))
        else $error("mean not the eight sample average");
endmodule // pacd_mean
`default_nettype wire

// ---- hdl/pacd_accum.sv ----
`timescale 1ns/1ns
`default_nettype none
module pacd_accum (
    input  wire logic                                 mclk,
    input  wire logic                                 rst,
    pacd_conv_if.sink                                 cv,
    output logic [pacd_pkg::NCH-1:0][pacd_pkg::ACC_W-1:0] acc,
    output logic [pacd_pkg::CNT_W-1:0]                count,
    output logic                                      ovf_event
);
    // ----------------------------------------
    // power sample
    // ----------------------------------------
    logic signed [pacd_pkg::PWR_W-1:0] power;
    logic [pacd_pkg::ACC_W-1:0]        acc_sel;
    logic [pacd_pkg::ACC_W:0]          sum_wide;
    logic                              sat_pos;
    logic                              sat_neg;
    logic [pacd_pkg::ACC_W-1:0]        next_acc;
    logic                              cnt_full;

    assign power = cv.sense
                 * $signed(cv.bus[pacd_pkg::SMP_W-1 -: pacd_pkg::BUS_MSB_W]);
    assign acc_sel = acc[cv.ch];
    assign sum_wide = {acc_sel[pacd_pkg::ACC_W-1], acc_sel}
                    + {{(pacd_pkg::ACC_W-pacd_pkg::PWR_W+1){power[30]}}, power};
    assign sat_pos = !sum_wide[pacd_pkg::ACC_W]
                   && sum_wide[pacd_pkg::ACC_W-1];
    assign sat_neg = sum_wide[pacd_pkg::ACC_W]
                   && !sum_wide[pacd_pkg::ACC_W-1];
    assign next_acc = sat_pos ? pacd_pkg::ACC_MAX
                    : sat_neg ? pacd_pkg::ACC_MIN
                    : sum_wide[pacd_pkg::ACC_W-1:0];
    assign cnt_full = count == pacd_pkg::CNT_MAX;

    // ----------------------------------------
    // accumulate
    // ----------------------------------------
    // add on every conversion
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc <= {pacd_pkg::NCH{pacd_pkg::ACC_RST}};
        end else if (cv.valid) begin
            acc[cv.ch] <= next_acc;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= pacd_pkg::CNT_RST;
        end else if (cv.cycle_done && !cnt_full) begin
            count <= count + 24'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ovf_event <= 1'b0;
        end else begin
            ovf_event <= (cv.valid && (sat_pos || sat_neg))
                      || (cv.cycle_done && cnt_full);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    acc_sat_a: assert property (cv.valid && sat_pos
        |=> acc[$past(cv.ch)] == pacd_pkg::ACC_MAX && ovf_event)
        else $error("accumulator did not saturate");
    acc_add_a: assert property (cv.valid && !sat_pos && !sat_neg
        |=> acc[$past(cv.ch)] == $past(sum_wide[pacd_pkg::ACC_W-1:0]))
        else $error("power sample not added");
    cnt_hold_a: assert property (cv.cycle_done && cnt_full
        |=> count == pacd_pkg::CNT_MAX && ovf_event)
        else $error("sample count wrapped");
    cnt_step_a: assert property (cv.cycle_done && !cnt_full
        |=> count == $past(count) + 24'h1)
        else $error("sample count not stepped");
endmodule // pacd_accum
`default_nettype wire

// ---- hdl/pacd_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - per channel, mean of last eight bus and eight sense samples
// - means recomputed once at each conversion cycle end
// - readable copies change only on any of the three refreshes
// - averages flagged unsettled until eight cycles after reset
// - four offset permute positions, all used every four conversion cycles
// - bus and sense carried as 17-bit signed internally
// - both unipolar: readable bus and sense are 16-bit unsigned
// - bus bipolar: readable bus truncated to 16-bit signed
// - sense bipolar: readable truncated, power keeps full 17 bits
// - power is sense times 14 bus msbs, 31-bit signed
// - power math always signed regardless of format
// - power summed into 48-bit accumulator per channel
// - accumulator saturates at its limit, never wraps
// - 24-bit sample count, overflow does not clear it
// - power sum bipolar when either format select is bipolar
// - each conversion adds its power sample; count steps once per cycle end
// - any accumulator or count overflow sets overflow flag
// - overflow flag and alert cleared by plain or general refresh
module pacd_top (
    input  wire logic                                   mclk,
    input  wire logic                                   rst,
    input  wire logic                                   conv_valid,
    input  wire logic [pacd_pkg::CH_W-1:0]              conv_ch,
    input  wire logic [pacd_pkg::SMP_W-1:0]             conv_bus,
    input  wire logic [pacd_pkg::SMP_W-1:0]             conv_sense,
    input  wire logic                                   cycle_done,
    input  wire logic                                   refresh,
    input  wire logic                                   refresh_values,
    input  wire logic                                   refresh_general,
    input  wire logic                                   bus_bipolar,
    input  wire logic                                   sense_bipolar,
    input  wire logic                                   alert_enable,
    output logic [pacd_pkg::PERM_W-1:0]                 bus_permute,
    output logic [pacd_pkg::PERM_W-1:0]                 sense_permute,
    output logic [pacd_pkg::NCH-1:0][pacd_pkg::OUT_W-1:0] bus_voltage,
    output logic [pacd_pkg::NCH-1:0][pacd_pkg::OUT_W-1:0] shunt_voltage,
    output logic [pacd_pkg::NCH-1:0][pacd_pkg::OUT_W-1:0] bus_voltage_mean,
    output logic [pacd_pkg::NCH-1:0][pacd_pkg::OUT_W-1:0] sense_voltage_mean,
    output logic [pacd_pkg::NCH-1:0][pacd_pkg::ACC_W-1:0] power_sum_store,
    output logic [pacd_pkg::CNT_W-1:0]                  sample_count,
    output logic                                        signed_format_select,
    output logic                                        averages_settled,
    output logic                                        overflow_flag,
    output logic                                        overflow_alert
);
    // ----------------------------------------
    // conversion path
    // ----------------------------------------
    pacd_conv_if cv ();

    pacd_pkg::pacd_smp_t last_bus   [pacd_pkg::NCH];
    pacd_pkg::pacd_smp_t last_sense [pacd_pkg::NCH];
    pacd_pkg::pacd_smp_t mean_bus   [pacd_pkg::NCH];
    pacd_pkg::pacd_smp_t mean_sense [pacd_pkg::NCH];

    logic [pacd_pkg::NCH-1:0][pacd_pkg::ACC_W-1:0] acc_live;
    logic [pacd_pkg::CNT_W-1:0]                    cnt_live;
    logic                                          ovf_event;
    logic [pacd_pkg::SETTLE_W-1:0]                 settle_cnt;
    logic [pacd_pkg::PERM_W-1:0]                   perm;

    assign cv.valid      = conv_valid;
    assign cv.ch         = conv_ch;
    assign cv.bus        = $signed(conv_bus);
    assign cv.sense      = $signed(conv_sense);
    assign cv.cycle_done = cycle_done;

    // ----------------------------------------
    // named decodes
    // ----------------------------------------
    logic                          any_refresh;
    logic                          ovf_clear;
    logic                          next_overflow;
    logic                          sum_bipolar;
    logic [pacd_pkg::SETTLE_W-1:0] next_settle;
    logic [pacd_pkg::PERM_W-1:0]   next_perm;

    assign any_refresh = refresh || refresh_values || refresh_general;
    assign ovf_clear   = refresh || refresh_general;
    // set wins over a same-cycle clear
    assign next_overflow = ovf_event || (overflow_flag && !ovf_clear);
    // either bipolar makes the sum bipolar
    assign sum_bipolar = bus_bipolar || sense_bipolar;
    // count conversion cycles up to eight
    assign next_settle = (cycle_done && settle_cnt != pacd_pkg::SETTLE_CYCLES)
                       ? settle_cnt + 4'h1 : settle_cnt;
    assign next_perm = cycle_done ? perm + 2'h1 : perm;

    // ----------------------------------------
    // latest samples and means
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int c = 0; c < pacd_pkg::NCH; c++) begin
                last_bus[c]   <= '0;
                last_sense[c] <= '0;
            end
        end else if (conv_valid) begin
            last_bus[conv_ch]   <= cv.bus;
            last_sense[conv_ch] <= cv.sense;
        end
    end

    // one mean per input per channel
    for (genvar c = 0; c < pacd_pkg::NCH; c++) begin : g_ch
        pacd_mean u_mean_bus (
            .mclk   (mclk),
            .rst    (rst),
            .push   (cycle_done),
            .sample (last_bus[c]),
            .mean   (mean_bus[c])
        );
        pacd_mean u_mean_sense (
            .mclk   (mclk),
            .rst    (rst),
            .push   (cycle_done),
            .sample (last_sense[c]),
            .mean   (mean_sense[c])
        );
    end

    pacd_accum u_accum (
        .mclk      (mclk),
        .rst       (rst),
        .cv        (cv.sink),
        .acc       (acc_live),
        .count     (cnt_live),
        .ovf_event (ovf_event)
    );

    // ----------------------------------------
    // status
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            settle_cnt       <= '0;
            averages_settled <= 1'b0;
            perm             <= pacd_pkg::PERM_RST;
            bus_permute      <= pacd_pkg::PERM_RST;
            sense_permute    <= pacd_pkg::PERM_RST;
            overflow_flag    <= 1'b0;
            overflow_alert   <= 1'b0;
        end else begin
            settle_cnt       <= next_settle;
            averages_settled <= next_settle == pacd_pkg::SETTLE_CYCLES;
            perm             <= next_perm;
            bus_permute      <= next_perm;
            sense_permute    <= next_perm;
            overflow_flag    <= next_overflow;
            overflow_alert   <= next_overflow && alert_enable;
        end
    end

    // ----------------------------------------
    // readable copies
    // ----------------------------------------
    // sums and count come from the same edge, so a capture never splits them
    // atomic capture
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_voltage          <= '0;
            shunt_voltage        <= '0;
            bus_voltage_mean     <= '0;
            sense_voltage_mean   <= '0;
            power_sum_store      <= '0;
            sample_count         <= pacd_pkg::CNT_RST;
            signed_format_select <= 1'b0;
        end else if (any_refresh) begin
            for (int c = 0; c < pacd_pkg::NCH; c++) begin
                bus_voltage[c] <=
                    pacd_pkg::fmt_result(last_bus[c], bus_bipolar);
                shunt_voltage[c] <=
                    pacd_pkg::fmt_result(last_sense[c], sense_bipolar);
                bus_voltage_mean[c] <=
                    pacd_pkg::fmt_result(mean_bus[c], bus_bipolar);
                sense_voltage_mean[c] <=
                    pacd_pkg::fmt_result(mean_sense[c], sense_bipolar);
            end
            power_sum_store      <= acc_live;
            sample_count         <= cnt_live;
            signed_format_select <= sum_bipolar;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ovf_set_a: assert property (ovf_event |=> overflow_flag)
        else $error("overflow event lost");
    ovf_keep_a: assert property (overflow_flag && !ovf_clear
        |=> overflow_flag)
        else $error("overflow flag dropped without clearing refresh");
    ovf_clear_a: assert property (ovf_clear && !ovf_event
        |=> !overflow_flag ##0 !overflow_alert)
        else $error("overflow flag not cleared by refresh");
    settle_at_a: assert property ($rose(averages_settled)
        |-> settle_cnt == pacd_pkg::SETTLE_CYCLES)
        else $error("averages settled at wrong count");
    copy_hold_a: assert property (!any_refresh
        |=> $stable(sample_count) && $stable(bus_voltage_mean))
        else $error("readable copy changed without refresh");
    copy_atomic_a: assert property (any_refresh
        |=> sample_count == $past(cnt_live)
            && power_sum_store == $past(acc_live))
        else $error("sum and count captured apart");
    perm_step_a: assert property (cycle_done
        |=> bus_permute == 2'($past(bus_permute) + 2'h1))
        else $error("permute position not advanced");
    bus_bip_a: assert property (any_refresh && bus_bipolar
        |=> bus_voltage[0] == $past(last_bus[0][16:1]))
        else $error("bipolar bus not truncated");
    sense_uni_a: assert property (any_refresh && !sense_bipolar
        && !last_sense[0][16]
        |=> shunt_voltage[0] == $past(last_sense[0][15:0]))
        else $error("unipolar sense wrong");
    sum_fmt_a: assert property (any_refresh
        |=> signed_format_select == $past(bus_bipolar || sense_bipolar))
        else $error("power sum format wrong");
endmodule // pacd_top
`default_nettype wire

// ---- bench/pacd_adc_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// adc front end, four channels a cycle
// ----------------------------------------
module pacd_adc_model (
    input  wire logic             mclk,
    input  wire logic             start,
    input  wire logic             slow,
    input  wire logic [3:0][16:0] bus_in,
    input  wire logic [3:0][16:0] sense_in,
    output logic                  conv_valid,
    output logic [1:0]            conv_ch,
    output logic [16:0]           conv_bus,
    output logic [16:0]           conv_sense,
    output logic                  cycle_done,
    output logic                  busy
);
    // released lines flip so a stale value never passes
    task automatic idle();
        conv_valid = 1'b0;
        conv_ch    = ~conv_ch;
        conv_bus   = ~conv_bus;
        conv_sense = ~conv_sense;
    endtask

    initial begin
        conv_valid = 1'b0;
        conv_ch    = 2'h0;
        conv_bus   = 17'h0;
        conv_sense = 17'h0;
        cycle_done = 1'b0;
        busy       = 1'b0;
        forever begin
            @(posedge mclk);
            if (start) begin
                busy = 1'b1;
                @(negedge mclk);
                for (int c = 0; c < 4; c++) begin
                    conv_valid = 1'b1;
                    conv_ch    = c[1:0];
                    conv_bus   = bus_in[c];
                    conv_sense = sense_in[c];
                    @(negedge mclk);
                    if (slow) begin
                        idle();
                        repeat (2) @(negedge mclk);
                    end
                end
                if (!slow) begin
                    idle();
                end
                cycle_done = 1'b1;
                @(negedge mclk);
                cycle_done = 1'b0;
                @(posedge mclk);
                busy = 1'b0;
            end
        end
    end
endmodule // pacd_adc_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // ----------------------------------------
    // signals and reference state
    // ----------------------------------------
    typedef struct {
        logic [3:0][15:0] bv;
        logic [3:0][15:0] sv;
        logic [3:0][15:0] bm;
        logic [3:0][15:0] sm;
        logic [3:0][47:0] acc;
        logic [23:0]      cnt;
        logic [1:0]       perm;
        logic             sfs;
        logic             settled;
    } pacd_note_t;

    logic                    mclk = 1'b0;
    logic                    rst;
    logic                    start;
    logic                    slow;
    logic                    busy;
    logic [3:0][16:0]        bus_in;
    logic [3:0][16:0]        sense_in;
    logic                    conv_valid;
    logic [1:0]              conv_ch;
    logic [16:0]             conv_bus;
    logic [16:0]             conv_sense;
    logic                    cycle_done;
    logic [3:0]              ev;
    logic                    bus_bip;
    logic                    sense_bip;
    logic                    alert_en;
    logic [1:0]              bus_perm;
    logic [1:0]              sense_perm;
    logic [3:0][15:0]        bv;
    logic [3:0][15:0]        sv;
    logic [3:0][15:0]        bm;
    logic [3:0][15:0]        sm;
    logic [3:0][47:0]        acc;
    logic [23:0]             cnt;
    logic                    sfs;
    logic                    settled;
    logic                    ovf;
    logic                    alert;
    logic [16:0]             hb [4][8];
    logic [16:0]             hs [4][8];
    logic signed [47:0]      racc [4];
    logic [23:0]             rcnt;
    logic [31:0]             seed = 32'h39;
    pacd_note_t              last;
    pacd_note_t              wn;
    pacd_note_t              q [$];
    int                      failures = 0;
    int                      samples_checked = 0;

    always #5 mclk = ~mclk;

    pacd_adc_model u_adc (.mclk(mclk), .start(start), .slow(slow),
        .bus_in(bus_in), .sense_in(sense_in), .conv_valid(conv_valid),
        .conv_ch(conv_ch), .conv_bus(conv_bus), .conv_sense(conv_sense),
        .cycle_done(cycle_done), .busy(busy));

    pacd_top u_dut (.mclk(mclk), .rst(rst), .conv_valid(conv_valid),
        .conv_ch(conv_ch), .conv_bus(conv_bus), .conv_sense(conv_sense),
        .cycle_done(cycle_done), .refresh(ev[0]), .refresh_values(ev[1]),
        .refresh_general(ev[2]), .bus_bipolar(bus_bip),
        .sense_bipolar(sense_bip), .alert_enable(alert_en),
        .bus_permute(bus_perm), .sense_permute(sense_perm),
        .bus_voltage(bv), .shunt_voltage(sv), .bus_voltage_mean(bm),
        .sense_voltage_mean(sm), .power_sum_store(acc),
        .sample_count(cnt), .signed_format_select(sfs),
        .averages_settled(settled), .overflow_flag(ovf),
        .overflow_alert(alert));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] fmt(input logic [16:0] v, input logic b);
        if (b) begin
            return v[16:1];
        end
        return v[16] ? 16'h0 : v[15:0];
    endfunction

    // floor of the signed mean, history starts at zero
    function automatic logic [16:0] avg(input logic [16:0] h [8]);
        logic signed [19:0] s;
        s = 20'sh0;
        for (int k = 0; k < 8; k++) begin
            s = s + $signed(h[k]);
        end
        return s[19:3];
    endfunction

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one conversion cycle of random samples, reference kept in step
    task automatic run_cycle(input logic sl);
        logic [31:0]        r;
        logic signed [47:0] p;
        logic signed [48:0] t;
        ev = 4'h0;
        for (int c = 0; c < 4; c++) begin
            r = xs();
            bus_in[c] = r[16:0];
            r = xs();
            sense_in[c] = r[16:0];
            p = $signed(sense_in[c]) * $signed(bus_in[c][16:3]);
            t = racc[c] + p;
            racc[c] = (t[48] == t[47]) ? t[47:0]
                    : (t[48] ? 48'h8000_0000_0000 : 48'h7fff_ffff_ffff);
            for (int k = 7; k > 0; k--) begin
                hb[c][k] = hb[c][k-1];
                hs[c][k] = hs[c][k-1];
            end
            hb[c][0] = bus_in[c];
            hs[c][0] = sense_in[c];
        end
        if (rcnt != 24'hff_ffff) begin
            rcnt = rcnt + 24'h1;
        end
        slow = sl;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        for (int w = 0; busy && w < 40; w++) begin
            @(negedge mclk);
        end
        // a front end that never finishes counts against the run
        if (busy !== 1'b0) begin
            failures++;
        end
        repeat (2) @(negedge mclk);
    endtask

    // kind 0 plain, 1 values only, 2 general call
    task automatic rf(input int kind);
        pacd_note_t n;
        for (int c = 0; c < 4; c++) begin
            n.bv[c] = fmt(hb[c][0], bus_bip);
            n.sv[c] = fmt(hs[c][0], sense_bip);
            n.bm[c] = fmt(avg(hb[c]), bus_bip);
            n.sm[c] = fmt(avg(hs[c]), sense_bip);
            n.acc[c] = racc[c];
        end
        n.cnt = rcnt;
        n.perm = rcnt[1:0];
        n.sfs = bus_bip | sense_bip;
        n.settled = (rcnt >= 24'h8);
        last = n;
        q.push_back(n);
        ev = 4'(1 << kind);
        @(negedge mclk);
    endtask

    // no refresh: readable copies must hold, live status moves on
    task automatic peek();
        pacd_note_t n;
        n = last;
        n.perm = rcnt[1:0];
        n.settled = (rcnt >= 24'h8);
        q.push_back(n);
        ev = 4'h8;
        @(negedge mclk);
    endtask

    task automatic results();
        $display("failures=%0d samples_checked=%0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // output watcher
    // ----------------------------------------
    always @(posedge mclk) begin
        if (!rst && ev != 4'h0) begin
            @(negedge mclk);
            wn = q.pop_front();
            for (int c = 0; c < 4; c++) begin
                chk(48'(bv[c]), 48'(wn.bv[c]));
                chk(48'(sv[c]), 48'(wn.sv[c]));
                chk(48'(bm[c]), 48'(wn.bm[c]));
                chk(48'(sm[c]), 48'(wn.sm[c]));
                chk(acc[c], wn.acc[c]);
            end
            chk(48'(cnt), 48'(wn.cnt));
            chk(48'(bus_perm), 48'(wn.perm));
            chk(48'(sense_perm), 48'(wn.perm));
            chk(48'(sfs), 48'(wn.sfs));
            chk(48'(settled), 48'(wn.settled));
            chk(48'({ovf, alert}), 48'h0);
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    // saturation needs about 2^18 full-scale samples: out of reach here
    initial begin
        rst = 1'b1;
        start = 1'b0;
        slow = 1'b0;
        bus_in = '0;
        sense_in = '0;
        ev = 4'h0;
        bus_bip = 1'b0;
        sense_bip = 1'b0;
        alert_en = 1'b0;
        rcnt = 24'h0;
        for (int c = 0; c < 4; c++) begin
            racc[c] = 48'sh0;
            for (int k = 0; k < 8; k++) begin
                hb[c][k] = 17'h0;
                hs[c][k] = 17'h0;
            end
        end
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        rf(0);
        for (int i = 0; i < 12; i++) begin
            bus_bip = i[0];
            sense_bip = i[1];
            alert_en = i[2];
            run_cycle(i[2]);
            peek();
            rf(i % 3);
            if (i[0]) begin
                rf((i + 1) % 3);
            end
        end
        ev = 4'h0;
        repeat (3) @(negedge mclk);
        results();
    end

    // about 180 cycles expected; about 28 times that cuts a hang
    initial begin
        #50000;
        failures++;
        results();
    end
endmodule // tb_top
`default_nettype wire
